// ==== core/gain_pkg.sv ====
// Constants for the DAC soft mute and mono mix stage.
// Shared by the stage and its verification; no surroundings assumed.
package gain_pkg;
   localparam logic [7:0] CONTROL_ONE_ADDR = 8'h21;
   localparam logic [7:0] LEFT_VOLUME_ADDR = 8'h1E;
   localparam logic [7:0] RIGHT_VOLUME_ADDR = 8'h1F;
   localparam logic [7:0] CHANNEL_ENABLE_ADDR = 8'h12;
   localparam logic [7:0] GAIN_STATUS_ADDR = 8'h40;
   localparam int MUTE_BIT = 3;
   localparam int UNMUTE_RAMP_BIT = 9;
   localparam int RATE_BIT = 10;
   localparam int MONO_BIT = 12;
   localparam int UPDATE_BIT = 8;
   localparam int LEFT_ENABLE_BIT = 1;
   localparam int RIGHT_ENABLE_BIT = 0;
   localparam logic [15:0] CONTROL_ONE_RESET = 16'h0008;
   localparam logic [7:0] VOLUME_RESET = 8'hC0;
   localparam logic [1:0] ENABLE_RESET = 2'h3;
   localparam logic [7:0] MUTE_CODE = 8'h00;
   localparam logic [7:0] FULL_CODE = 8'hC0;
   localparam int FAST_DIVIDE = 2;
   localparam int SLOW_DIVIDE = 32;
   localparam real FAST_RAMP_MAX_MS = 10.7;
   localparam real SLOW_RAMP_MAX_MS = 171.0;
   localparam int FIFO_DEPTH = 16;
   localparam int SAMPLE_WIDTH = 24;
endpackage

// ==== core/sample_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] count_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = store[rd_reg];
   always_ff @(posedge clock_i)
   begin
      if (push)
      begin
         store[wr_reg] <= in_data_i;
      end
   end
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== core/dac_soft_mute_mono_mix.sv ====
// Soft mute, volume and mono mix gain stage ahead of a stereo DAC pair.
// Assumes samples arrive by valid/ready on clock_i, with the register port on clock_i too.
// Summary of operation
// - Volume code 0 mutes, 1 is minimum, each code adds 0.375 dB, C0h and up is 0 dB.
// - Both channel volume codes take effect together when a one is written to the update bit.
// - Soft mute lowers the gain step by step toward silence.
// - Mute bit 3 resets to one so the DAC starts muted; software clears it to un-mute.
// - With bit 9 at zero, un-mute restores the programmed volumes at once.
// - With bit 9 at one, un-mute ramps the gain up to the programmed volumes.
// - Bit 10 picks a ramp step every 2 samples (zero) or every 32 samples (one).
// - A full ramp at 48 kHz lasts at most 10.7 ms fast or 171 ms slow.
// - Ramp time grows with the gap between muted and programmed gain.
// - Mono-mix bit 12 sums left and right into one signal; clear gives stereo.
// - The mono result goes to whichever channel is enabled.
// - The mono sum is attenuated by 6 dB.
// - In mono mode the disabled channel outputs nothing.
// - With both channels enabled the stage is stereo regardless of bit 12.
`timescale 1ns/1ps
module dac_soft_mute_mono_mix #(
   parameter int WIDTH = gain_pkg::SAMPLE_WIDTH,
   parameter int DEPTH = gain_pkg::FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [15:0] reg_rdata_o,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] left_sample_i,
   input wire logic [WIDTH-1:0] right_sample_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] left_sample_o,
   output logic [WIDTH-1:0] right_sample_o
);
   // Software state
   logic [15:0] control_reg;
   logic [7:0] left_pending_reg;
   logic [7:0] right_pending_reg;
   logic [7:0] left_volume_code_reg;
   logic [7:0] right_volume_code_reg;
   logic left_channel_enable_reg;
   logic right_channel_enable_reg;
   logic [15:0] rdata_reg;
   // Ramp state
   logic [7:0] left_gain_reg;
   logic [7:0] right_gain_reg;
   logic [4:0] ramp_div_reg;
   logic mute_prev_reg;
   logic ramping_up_reg;

   wire soft_mute = control_reg[gain_pkg::MUTE_BIT];
   wire unmute_ramp_select = control_reg[gain_pkg::UNMUTE_RAMP_BIT];
   wire mute_ramp_rate_select = control_reg[gain_pkg::RATE_BIT];
   wire mono_mix = control_reg[gain_pkg::MONO_BIT];

   wire write_control = reg_write_i && (reg_addr_i == gain_pkg::CONTROL_ONE_ADDR);
   wire write_left = reg_write_i && (reg_addr_i == gain_pkg::LEFT_VOLUME_ADDR);
   wire write_right = reg_write_i && (reg_addr_i == gain_pkg::RIGHT_VOLUME_ADDR);
   wire write_enable = reg_write_i && (reg_addr_i == gain_pkg::CHANNEL_ENABLE_ADDR);
   wire volume_update_strobe = (write_left || write_right)
      && reg_wdata_i[gain_pkg::UPDATE_BIT];

   // Ramp tick: one step per 2 or 32 accepted samples
   localparam logic [4:0] FAST_LAST = 5'(gain_pkg::FAST_DIVIDE - 1);
   localparam logic [4:0] SLOW_LAST = 5'(gain_pkg::SLOW_DIVIDE - 1);
   wire [4:0] div_last = mute_ramp_rate_select ? SLOW_LAST : FAST_LAST;

   // FIFO in the sample path
   logic fifo_valid;
   logic fifo_ready;
   logic [2*WIDTH-1:0] fifo_data;
   sample_fifo #(
      .WIDTH(2 * WIDTH),
      .DEPTH(DEPTH)
   ) fifo_inst (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .in_data_i({left_sample_i, right_sample_i}),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready),
      .out_data_o(fifo_data)
   );

   // Output stage holds one sample; accepts when empty or draining
   logic out_valid_reg;
   assign out_valid_o = out_valid_reg;
   assign fifo_ready = !out_valid_reg || out_ready_i;
   wire sample_step = fifo_valid && fifo_ready;
   wire ramp_tick = sample_step && (ramp_div_reg >= div_last);

   // Linear gain from code: 0.375 dB steps built as 2^(-k/16) per octave of 16 codes
   function automatic logic [16:0] code_to_gain(input logic [7:0] code);
      logic [7:0] att;
      logic [3:0] frac;
      logic [3:0] oct;
      logic [15:0] mant;
      att = 8'h00;
      frac = 4'h0;
      oct = 4'h0;
      mant = 16'h0000;
      if (code == gain_pkg::MUTE_CODE)
      begin
         code_to_gain = 17'h00000;
      end
      else
      begin
         att = (code >= gain_pkg::FULL_CODE) ? 8'h00 : gain_pkg::FULL_CODE - code;
         frac = att[3:0];
         oct = att[7:4];
         // 0.375 dB * 16 = 6 dB per octave of codes
         case (frac)
            4'h0: mant = 16'hFFFF;
            4'h1: mant = 16'hF5A1;
            4'h2: mant = 16'hEBDC;
            4'h3: mant = 16'hE2A4;
            4'h4: mant = 16'hD9F0;
            4'h5: mant = 16'hD1B4;
            4'h6: mant = 16'hC9E8;
            4'h7: mant = 16'hC281;
            4'h8: mant = 16'hBB76;
            4'h9: mant = 16'hB4C0;
            4'hA: mant = 16'hAE56;
            4'hB: mant = 16'hA833;
            4'hC: mant = 16'hA24F;
            4'hD: mant = 16'h9CA4;
            4'hE: mant = 16'h972D;
            4'hF: mant = 16'h91E4;
            default: mant = 16'hFFFF;
         endcase
         // Whole octaves are exact powers of two, so C0h and up is unity
         code_to_gain = (frac == 4'h0) ? (17'h10000 >> oct) : (17'(mant) >> oct);
      end
   endfunction

   function automatic logic [WIDTH-1:0] apply_gain(input logic [WIDTH-1:0] s,
                                                   input logic [16:0] g);
      logic signed [WIDTH+17:0] prod;
      prod = $signed(s) * $signed({1'b0, g});
      apply_gain = prod[WIDTH+15:16];
   endfunction

   // Mono mix and channel routing
   wire [WIDTH-1:0] left_in = fifo_data[2*WIDTH-1:WIDTH];
   wire [WIDTH-1:0] right_in = fifo_data[WIDTH-1:0];
   wire both_enabled = left_channel_enable_reg && right_channel_enable_reg;
   wire mono_active = mono_mix && !both_enabled;
   wire signed [WIDTH:0] mono_sum = $signed({left_in[WIDTH-1], left_in})
      + $signed({right_in[WIDTH-1], right_in});
   wire [WIDTH-1:0] mono_half = mono_sum[WIDTH:1];
   wire [WIDTH-1:0] left_pre = !mono_active ? left_in
      : (left_channel_enable_reg ? mono_half : '0);
   wire [WIDTH-1:0] right_pre = !mono_active ? right_in
      : (right_channel_enable_reg ? mono_half : '0);
   wire [WIDTH-1:0] left_scaled = apply_gain(left_pre, code_to_gain(left_gain_reg));
   wire [WIDTH-1:0] right_scaled = apply_gain(right_pre, code_to_gain(right_gain_reg));

   // Target and stepping per channel
   function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
      logic [7:0] c;
      c = (cur > gain_pkg::FULL_CODE) ? gain_pkg::FULL_CODE : cur;
      if (c < tgt)
      begin
         step_toward = c + 8'h01;
      end
      else if (c > tgt)
      begin
         step_toward = c - 8'h01;
      end
      else
      begin
         step_toward = cur;
      end
   endfunction

   wire unmute_edge = mute_prev_reg && !soft_mute;
   wire [7:0] left_target = soft_mute ? gain_pkg::MUTE_CODE : left_volume_code_reg;
   wire [7:0] right_target = soft_mute ? gain_pkg::MUTE_CODE : right_volume_code_reg;
   // Clamp codes above C0h onto C0h so ramps stay proportional
   wire [7:0] left_tgt_c = (left_target > gain_pkg::FULL_CODE) ? gain_pkg::FULL_CODE
      : left_target;
   wire [7:0] right_tgt_c = (right_target > gain_pkg::FULL_CODE) ? gain_pkg::FULL_CODE
      : right_target;
   // A ramped un-mute must not jump in the cycle of the edge
   wire ramp_start = unmute_edge && unmute_ramp_select;
   wire ramp_mode = soft_mute || ramping_up_reg || ramp_start;
   wire jump_now = !ramp_mode;
   wire [7:0] left_gain_next = jump_now ? left_tgt_c
      : (ramp_tick ? step_toward(left_gain_reg, left_tgt_c) : left_gain_reg);
   wire [7:0] right_gain_next = jump_now ? right_tgt_c
      : (ramp_tick ? step_toward(right_gain_reg, right_tgt_c) : right_gain_reg);
   wire ramp_done = (left_gain_next == left_tgt_c) && (right_gain_next == right_tgt_c);

   // Register file
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         control_reg <= gain_pkg::CONTROL_ONE_RESET;
         left_pending_reg <= gain_pkg::VOLUME_RESET;
         right_pending_reg <= gain_pkg::VOLUME_RESET;
         left_volume_code_reg <= gain_pkg::VOLUME_RESET;
         right_volume_code_reg <= gain_pkg::VOLUME_RESET;
         left_channel_enable_reg <= gain_pkg::ENABLE_RESET[1];
         right_channel_enable_reg <= gain_pkg::ENABLE_RESET[0];
      end
      else
      begin
         if (write_control)
         begin
            control_reg <= reg_wdata_i;
         end
         if (write_left)
         begin
            left_pending_reg <= reg_wdata_i[7:0];
         end
         if (write_right)
         begin
            right_pending_reg <= reg_wdata_i[7:0];
         end
         if (volume_update_strobe)
         begin
            left_volume_code_reg <= write_left ? reg_wdata_i[7:0] : left_pending_reg;
            right_volume_code_reg <= write_right ? reg_wdata_i[7:0] : right_pending_reg;
         end
         if (write_enable)
         begin
            left_channel_enable_reg <= reg_wdata_i[gain_pkg::LEFT_ENABLE_BIT];
            right_channel_enable_reg <= reg_wdata_i[gain_pkg::RIGHT_ENABLE_BIT];
         end
      end
   end

   // Read port, data valid one cycle after the strobe
   wire [15:0] read_mux =
      (reg_addr_i == gain_pkg::CONTROL_ONE_ADDR) ? control_reg :
      (reg_addr_i == gain_pkg::LEFT_VOLUME_ADDR) ? {8'h00, left_pending_reg} :
      (reg_addr_i == gain_pkg::RIGHT_VOLUME_ADDR) ? {8'h00, right_pending_reg} :
      (reg_addr_i == gain_pkg::CHANNEL_ENABLE_ADDR) ?
         {14'h0000, left_channel_enable_reg, right_channel_enable_reg} :
      (reg_addr_i == gain_pkg::GAIN_STATUS_ADDR) ? {left_gain_reg, right_gain_reg} :
      16'h0000;
   assign reg_rdata_o = rdata_reg;
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         rdata_reg <= 16'h0000;
      end
      else
      begin
         rdata_reg <= reg_read_i ? read_mux : 16'h0000;
      end
   end

   // Gain ramp
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         left_gain_reg <= gain_pkg::MUTE_CODE;
         right_gain_reg <= gain_pkg::MUTE_CODE;
         ramp_div_reg <= 5'h00;
         mute_prev_reg <= 1'b1;
         ramping_up_reg <= 1'b0;
      end
      else
      begin
         mute_prev_reg <= soft_mute;
         if (sample_step)
         begin
            ramp_div_reg <= ramp_tick ? 5'h00 : ramp_div_reg + 5'h01;
         end
         if (soft_mute)
         begin
            ramping_up_reg <= 1'b0;
         end
         else if (unmute_edge)
         begin
            ramping_up_reg <= unmute_ramp_select;
         end
         else if (ramping_up_reg && ramp_done)
         begin
            ramping_up_reg <= 1'b0;
         end
         if (unmute_edge && !unmute_ramp_select)
         begin
            left_gain_reg <= left_tgt_c;
            right_gain_reg <= right_tgt_c;
         end
         else if (ramp_mode || jump_now)
         begin
            left_gain_reg <= left_gain_next;
            right_gain_reg <= right_gain_next;
         end
      end
   end

   // Output samples
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         out_valid_reg <= 1'b0;
         left_sample_o <= '0;
         right_sample_o <= '0;
      end
      else if (fifo_ready)
      begin
         out_valid_reg <= fifo_valid;
         if (fifo_valid)
         begin
            left_sample_o <= left_scaled;
            right_sample_o <= right_scaled;
         end
      end
   end
endmodule

// ==== tb/gain_properties.sv ====
// Port checker for the gain stage.
// Bound to every dac_soft_mute_mono_mix; shadows writes to the control registers.
`timescale 1ns/1ps
module gain_properties #(
   parameter int WIDTH = 24
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [WIDTH-1:0] left_sample_o,
   input wire logic [WIDTH-1:0] right_sample_o
);
   logic [15:0] ctrl_reg;
   logic [1:0] enable_reg;
   logic ctrl_written_reg;
   wire ctrl_wr = reg_write_i && reg_addr_i == gain_pkg::CONTROL_ONE_ADDR;
   wire en_wr = reg_write_i && reg_addr_i == gain_pkg::CHANNEL_ENABLE_ADDR;
   wire mono_mode = ctrl_reg[gain_pkg::MONO_BIT] && enable_reg != 2'h3;
   wire mapped = reg_addr_i inside {gain_pkg::CONTROL_ONE_ADDR, gain_pkg::LEFT_VOLUME_ADDR,
      gain_pkg::RIGHT_VOLUME_ADDR, gain_pkg::CHANNEL_ENABLE_ADDR, gain_pkg::GAIN_STATUS_ADDR};
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         ctrl_reg <= gain_pkg::CONTROL_ONE_RESET;
         enable_reg <= gain_pkg::ENABLE_RESET;
         ctrl_written_reg <= 1'b0;
      end
      else
      begin
         if (ctrl_wr)
            ctrl_reg <= reg_wdata_i;
         if (en_wr)
            enable_reg <= reg_wdata_i[1:0];
         if (ctrl_wr)
            ctrl_written_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_ctrl_write;
      ctrl_wr;
   endsequence
   sequence s_ctrl_read;
      reg_read_i && reg_addr_i == gain_pkg::CONTROL_ONE_ADDR;
   endsequence
   a_ctrl_echo: assert property (
      s_ctrl_write ##1 s_ctrl_read |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("control readback differs from write");
   a_ctrl_reset: assert property (
      s_ctrl_read ##0 !ctrl_written_reg |=> reg_rdata_o == gain_pkg::CONTROL_ONE_RESET)
      else $error("control reset value wrong");
   a_muted_start: assert property (
      out_valid_o && !ctrl_written_reg |-> left_sample_o == '0 && right_sample_o == '0)
      else $error("output not silent before unmute");
   a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside read");
   a_unmapped_zero: assert property (reg_read_i && !mapped |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_status_clamp: assert property (
      reg_read_i && reg_addr_i == gain_pkg::GAIN_STATUS_ADDR |=>
      reg_rdata_o[15:8] <= 8'hC0 && reg_rdata_o[7:0] <= 8'hC0)
      else $error("gain code above full scale");
   a_mono_silent: assert property (out_valid_o && mono_mode |->
      (enable_reg[1] || left_sample_o == '0) && (enable_reg[0] || right_sample_o == '0))
      else $error("disabled channel not silent in mono");
   a_out_hold: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(left_sample_o) && $stable(right_sample_o))
      else $error("output pair dropped while stalled");
endmodule
bind dac_soft_mute_mono_mix gain_properties #(.WIDTH(WIDTH)) checker_inst (
   .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
   .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
   .left_sample_o(left_sample_o), .right_sample_o(right_sample_o));

// ==== tb/sample_source.sv ====
// Upstream sample path model feeding the gain stage.
// Called by the testbench just after a rising edge.
`timescale 1ns/1ps
module sample_source #(
   parameter int WIDTH = 24
) (
   input wire logic clock_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [WIDTH-1:0] left_o,
   output logic [WIDTH-1:0] right_o
);
   initial
   begin
      valid_o = 1'b0;
      left_o = '0;
      right_o = '0;
   end
   // Holds the pair until the edge that takes it
   task automatic send(input logic [WIDTH-1:0] l, input logic [WIDTH-1:0] r);
      valid_o <= 1'b1;
      left_o <= l;
      right_o <= r;
      @(posedge clock_i);
      while (!ready_i)
         @(posedge clock_i);
   endtask
   // Released lines show the inverse of the last pair
   task automatic idle();
      valid_o <= 1'b0;
      left_o <= ~left_o;
      right_o <= ~right_o;
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the gain stage.
// Expected pairs are queued by the driver and compared by the output monitor.
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module testbench;
   localparam int W = gain_pkg::SAMPLE_WIDTH;
   typedef struct {logic chk; logic [W-1:0] l; logic [W-1:0] r;} note_type;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   logic out_ready_i = 1'b1;
   logic hold_sink = 1'b0;
   logic in_valid, in_ready, out_valid;
   logic [W-1:0] lin, rin, lout, rout;
   logic [15:0] rdata, d;
   int err_count = 0;
   int cmp_count = 0;
   note_type exp_q[$];
   note_type n;
   always #2 clock_i = ~clock_i;
   sample_source #(.WIDTH(W)) src (.clock_i(clock_i), .ready_i(in_ready), .valid_o(in_valid),
      .left_o(lin), .right_o(rin));
   dac_soft_mute_mono_mix dut (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(rdata), .in_valid_i(in_valid), .in_ready_o(in_ready),
      .left_sample_i(lin), .right_sample_i(rin), .out_valid_o(out_valid),
      .out_ready_i(out_ready_i), .left_sample_o(lout), .right_sample_o(rout));
   always @(posedge clock_i)
      out_ready_i <= hold_sink ? 1'b0 : 1'($urandom_range(0, 3) != 0);
   always @(posedge clock_i)
      if (!srst_i && out_valid && out_ready_i)
      begin
         if (exp_q.size() != 0)
         begin
            n = exp_q.pop_front();
            if (n.chk)
            begin
               `CHECK(lout, n.l)
               `CHECK(rout, n.r)
            end
         end
         else
            `CHECK(out_valid, 1'b0)
      end
   task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic echo);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
      reg_read_i <= echo;
      if (echo)
      begin
         @(posedge clock_i);
         reg_read_i <= 1'b0;
         #1 `CHECK(rdata, v)
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      `CHECK(d, e)
   endtask
   task automatic put(input logic c, input logic [W-1:0] l, r, el, er);
      exp_q.push_back('{c, el, er});
      src.send(l, r);
   endtask
   // Modes: 0 unchecked, 1 unity, 2 silent, 3 left silent, 4 mono left, 5 mono right
   task automatic run(input int cnt, input int m);
      logic [W-1:0] l, r;
      logic signed [W+1:0] s;
      int k;
      repeat (cnt)
      begin
         l = W'($urandom);
         r = W'($urandom);
         l[0] = 1'b0;
         r[0] = 1'b0;
         s = ($signed(l) + $signed(r)) >>> 1;
         case (m)
            1: put(1'b1, l, r, l, r);
            2: put(1'b1, l, r, '0, '0);
            3: put(1'b1, l, r, '0, r);
            4: put(1'b1, l, r, s[W-1:0], '0);
            5: put(1'b1, l, r, '0, s[W-1:0]);
            default: put(1'b0, l, r, '0, '0);
         endcase
      end
      src.idle();
      k = 0;
      while (exp_q.size() != 0 && k < 3000)
      begin
         @(posedge clock_i);
         k++;
      end
      `CHECK(exp_q.size(), 0)
      repeat (3) @(posedge clock_i);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clock_i);
      err_count++;
      results();
   end
   initial
   begin
      void'($urandom(75));
      repeat (5) @(posedge clock_i);
      srst_i <= 1'b0;
      rdc(gain_pkg::CONTROL_ONE_ADDR, gain_pkg::CONTROL_ONE_RESET);
      rdc(gain_pkg::CHANNEL_ENABLE_ADDR, {14'h0000, gain_pkg::ENABLE_RESET});
      rdc(gain_pkg::GAIN_STATUS_ADDR, 16'h0000);
      rdc(8'h55, 16'h0000);
      run(4, 2);
      $display("test reset_mute done");
      wr(gain_pkg::CONTROL_ONE_ADDR, 16'h0000, 1'b1);
      run(1, 0);
      rdc(gain_pkg::GAIN_STATUS_ADDR, 16'hC0C0);
      run(8, 1);
      hold_sink <= 1'b1;
      fork
         run(20, 1);
      join_none
      repeat (60) @(posedge clock_i);
      `CHECK(in_ready, 1'b0)
      hold_sink <= 1'b0;
      wait fork;
      $display("test unmute_fill done");
      wr(gain_pkg::LEFT_VOLUME_ADDR, 16'h0000, 1'b0);
      run(4, 1);
      wr(gain_pkg::RIGHT_VOLUME_ADDR, 16'h01C0, 1'b0);
      rdc(gain_pkg::GAIN_STATUS_ADDR, 16'h00C0);
      run(6, 3);
      wr(gain_pkg::LEFT_VOLUME_ADDR, 16'h01E0, 1'b0);
      rdc(gain_pkg::GAIN_STATUS_ADDR, 16'hC0C0);
      $display("test volume done");
      wr(gain_pkg::CHANNEL_ENABLE_ADDR, 16'h0002, 1'b0);
      wr(gain_pkg::CONTROL_ONE_ADDR, 16'h1000, 1'b1);
      run(8, 4);
      wr(gain_pkg::CHANNEL_ENABLE_ADDR, 16'h0001, 1'b0);
      run(8, 5);
      wr(gain_pkg::CHANNEL_ENABLE_ADDR, 16'h0003, 1'b0);
      run(4, 1);
      $display("test mono done");
      wr(gain_pkg::CONTROL_ONE_ADDR, 16'h0208, 1'b1);
      run(20, 0);
      rd(gain_pkg::GAIN_STATUS_ADDR);
      `CHECK(d[15:8] >= 8'hB5 && d[15:8] <= 8'hB7 && d[7:0] == d[15:8], 1'b1)
      run(380, 0);
      rdc(gain_pkg::GAIN_STATUS_ADDR, 16'h0000);
      run(4, 2);
      wr(gain_pkg::CONTROL_ONE_ADDR, 16'h0600, 1'b1);
      run(64, 0);
      rd(gain_pkg::GAIN_STATUS_ADDR);
      `CHECK(d[15:8] >= 8'h01 && d[15:8] <= 8'h03 && d[7:0] == d[15:8], 1'b1)
      $display("test ramps done");
      results();
   end
endmodule
